// *** core/card_specific_data_register.sv ***
// card-specific data register: fixed fields, programmable part, serial readout
// assumes a command decoder upstream that issues read and program requests
//
// Function
// (RULE_01) only programmable fields change on program command; others ignore writes; the code instead rejects a whole command whose read-only bits differ
// (RULE_02) format group, copy, permanent protect, file format write once
// (RULE_03) temporary protect, ecc, checksum rewritable and kept across resets
// (RULE_04) reserved bits always read as zero
// (RULE_05) read access time code 7Fh at bits 119:112
// (RULE_06) read access cycle code 01h at bits 111:104
// (RULE_07) max bus clock code 32h at bits 103:96
// (RULE_08) read block length code 9 at bits 83:80
// (RULE_09) partial-block reads unsupported, bit 79 zero
// (RULE_10) write block length code 9 at bits 25:22
// (RULE_11) partial-block writes unsupported, bit 21 zero
// (RULE_12) protect group available, bit 31 one
// (RULE_13) protect group size code 0Fh at bits 36:32
// (RULE_14) erase group size and multiplier both 1Fh
// (RULE_15) read returns all 128 bits msb first with current programmed values
`timescale 1ns/100ps
`include "csd_cfg.svh"
module card_specific_data_register (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // program request
   input wire logic prog_valid_i,
   input wire logic [`CSD_WIDTH-1:0] prog_data_i,
   // read request
   input wire logic read_req_i,
   // serial answer
   output logic read_busy_o,
   output logic read_bit_o,
   output logic read_bit_valid_o,
   output logic read_last_o,
   // parallel view and program reject flag
   output logic [`CSD_WIDTH-1:0] card_specific_data_o,
   output logic prog_reject_o
);
   // ************************************
   // state
   // ************************************
   typedef struct packed {
      csd_pkg::mode_type mode;
      logic [`CSD_BIT_CNT_W-1:0] cnt;
      logic [`CSD_WIDTH-1:0] shreg;
      logic bit_out;
      logic bit_valid;
      logic last;
      logic [`CSD_WIDTH-1:0] view;
      logic reject;
   } state_type;
   state_type s;
   state_type next_s;

   csd_pkg::otp_type otp_cur;
   logic [4:0] lock_cur;
   csd_pkg::multi_type multi_cur;
   csd_pkg::otp_type otp_new;
   logic [4:0] lock_new;
   csd_pkg::multi_type multi_new;
   logic store_wr;
   logic fixed_mismatch;
   logic [`CSD_WIDTH-1:0] image;

   // ************************************
   // register image
   // ************************************
   function automatic logic [`CSD_WIDTH-1:0] build_image(input csd_pkg::otp_type o,
                                                         input csd_pkg::multi_type m);
      logic [`CSD_WIDTH-1:0] r;
      r = '0; // [RULE_04]
      r[`CSD_STRUCT_RNG] = `CSD_STRUCT_VAL;
      r[`CSD_SPEC_RNG] = `CSD_SPEC_VAL;
      r[`CSD_ACCESS_TIME_RNG] = `CSD_ACCESS_TIME_VAL; // [RULE_05]
      r[`CSD_ACCESS_CYCLE_RNG] = `CSD_ACCESS_CYCLE_VAL; // [RULE_06]
      r[`CSD_SPEED_RNG] = `CSD_SPEED_VAL; // [RULE_07]
      r[`CSD_CLASSES_RNG] = `CSD_CLASSES_VAL;
      r[`CSD_RD_BLK_RNG] = `CSD_RD_BLK_VAL; // [RULE_08]
      r[`CSD_RD_PARTIAL_POS] = `CSD_RD_PARTIAL_VAL; // [RULE_09]
      r[`CSD_DEV_SIZE_RNG] = `CSD_DEV_SIZE_VAL;
      r[`CSD_SIZE_MULT_RNG] = `CSD_SIZE_MULT_VAL;
      r[`CSD_ERASE_SIZE_RNG] = `CSD_ERASE_SIZE_VAL; // [RULE_14]
      r[`CSD_ERASE_MULT_RNG] = `CSD_ERASE_MULT_VAL; // [RULE_14]
      r[`CSD_WP_SIZE_RNG] = `CSD_WP_SIZE_VAL; // [RULE_13]
      r[`CSD_WP_AVAIL_POS] = `CSD_WP_AVAIL_VAL; // [RULE_12]
      r[`CSD_R2W_RNG] = `CSD_R2W_VAL;
      r[`CSD_WR_BLK_RNG] = `CSD_WR_BLK_VAL; // [RULE_10]
      r[`CSD_WR_PARTIAL_POS] = `CSD_WR_PARTIAL_VAL; // [RULE_11]
      r[`CSD_FMT_GRP_POS] = o.format_group_bit;
      r[`CSD_COPY_POS] = o.copy_bit;
      r[`CSD_PERM_POS] = o.permanent_protect_bit;
      r[`CSD_TMP_POS] = m.temporary_protect_bit;
      r[`CSD_FILE_FMT_RNG] = o.file_format;
      r[`CSD_ECC_RNG] = m.ecc_code;
      r[`CSD_CRC_RNG] = m.crc_code;
      r[`CSD_BIT0_POS] = `CSD_BIT0_VAL;
      return r;
   endfunction : build_image

   assign image = build_image(otp_cur, multi_cur);

   // ************************************
   // program merge
   // ************************************
   // read-only part of the request must match the current image
   assign fixed_mismatch = (prog_data_i[`CSD_WIDTH-1:`CSD_PROG_LSB] != image[`CSD_WIDTH-1:`CSD_PROG_LSB]); // [RULE_01]

   always_comb begin
      otp_new = otp_cur;
      lock_new = lock_cur;
      // a written field locks; a locked field keeps its value
      if (!lock_cur[`CSD_LOCK_FMT_GRP]) begin
         otp_new.format_group_bit = prog_data_i[`CSD_FMT_GRP_POS];
         lock_new[`CSD_LOCK_FMT_GRP] = 1'b1;
      end
      if (!lock_cur[`CSD_LOCK_COPY]) begin
         otp_new.copy_bit = prog_data_i[`CSD_COPY_POS];
         lock_new[`CSD_LOCK_COPY] = 1'b1;
      end
      if (!lock_cur[`CSD_LOCK_PERM]) begin
         otp_new.permanent_protect_bit = prog_data_i[`CSD_PERM_POS];
         lock_new[`CSD_LOCK_PERM] = 1'b1;
      end
      if (!lock_cur[`CSD_LOCK_FILE_FMT]) begin
         otp_new.file_format = prog_data_i[`CSD_FILE_FMT_RNG];
         lock_new[`CSD_LOCK_FILE_FMT] = 1'b1;
      end
      lock_new[`CSD_LOCK_SPARE] = 1'b0;
      multi_new.temporary_protect_bit = prog_data_i[`CSD_TMP_POS]; // [RULE_03]
      multi_new.ecc_code = prog_data_i[`CSD_ECC_RNG]; // [RULE_03]
      multi_new.crc_code = prog_data_i[`CSD_CRC_RNG]; // [RULE_03]
   end // [RULE_02]

   assign store_wr = prog_valid_i && !rst_i && !fixed_mismatch && (s.mode == csd_pkg::idle_st); // [RULE_01]

   csd_store u_store (
      .ref_clk_i(ref_clk_i),
      .wr_en_i(store_wr),
      .otp_wr_i(otp_new),
      .otp_lock_wr_i(lock_new),
      .multi_wr_i(multi_new),
      .otp_o(otp_cur),
      .otp_lock_o(lock_cur),
      .multi_o(multi_cur)
   );

   // ************************************
   // readout sequencer
   // ************************************
   always_comb begin
      next_s = s;
      next_s.bit_valid = 1'b0;
      next_s.last = 1'b0;
      next_s.view = image;
      next_s.reject = prog_valid_i && !store_wr;
      case (s.mode)
         csd_pkg::idle_st: begin
            if (read_req_i) begin
               next_s.mode = csd_pkg::shift_st;
               next_s.shreg = image; // [RULE_15]
               next_s.cnt = '0;
            end
         end
         csd_pkg::shift_st: begin
            next_s.bit_out = s.shreg[`CSD_WIDTH-1]; // [RULE_15]
            next_s.bit_valid = 1'b1;
            next_s.shreg = {s.shreg[`CSD_WIDTH-2:0], 1'b0};
            next_s.cnt = s.cnt + 1'b1;
            if (s.cnt == `CSD_LAST_BIT) begin
               next_s.last = 1'b1;
               next_s.mode = csd_pkg::idle_st;
            end
         end
         default: begin
            next_s.mode = csd_pkg::idle_st;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         s <= '{mode: csd_pkg::idle_st, default: '0};
      end else begin
         s <= next_s;
      end
   end

   assign read_busy_o = (s.mode == csd_pkg::shift_st);
   assign read_bit_o = s.bit_out;
   assign read_bit_valid_o = s.bit_valid;
   assign read_last_o = s.last;
   assign card_specific_data_o = s.view;
   assign prog_reject_o = s.reject;

   // ************************************
   // checks of the fixed fields and of the parallel view
   // ************************************
   fixed_fields_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE_05]
      $past(!rst_i) |-> card_specific_data_o[119:96] == 24'h7F0132 && card_specific_data_o[83:79] == 5'h12)
      else $error("fixed timing or read block fields wrong");
   geometry_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE_14]
      $past(!rst_i) |-> card_specific_data_o[46:31] == 16'hFFDF && card_specific_data_o[25:21] == 5'h12)
      else $error("erase or protect geometry wrong");
   reserved_zero_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE_04]
      $past(!rst_i) |-> card_specific_data_o[121:120] == 2'h0 && card_specific_data_o[75:74] == 2'h0
      && card_specific_data_o[20:17] == 4'h0)
      else $error("reserved bits not zero");
   access_time_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE_05]
      $past(!rst_i) |-> card_specific_data_o[119:112] == 8'h7F)
      else $error("read access time code wrong");
   access_cycle_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE_06]
      $past(!rst_i) |-> card_specific_data_o[111:104] == 8'h01)
      else $error("read access cycle code wrong");
   bus_speed_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE_07]
      $past(!rst_i) |-> card_specific_data_o[103:96] == 8'h32)
      else $error("bus clock code wrong");
   read_block_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE_08]
      $past(!rst_i) |-> card_specific_data_o[83:80] == 4'h9)
      else $error("read block length code wrong");
   read_partial_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE_09]
      $past(!rst_i) |-> card_specific_data_o[79] == 1'b0)
      else $error("partial read flag set");
   write_block_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE_10]
      $past(!rst_i) |-> card_specific_data_o[25:22] == 4'h9)
      else $error("write block length code wrong");
   write_partial_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE_11]
      $past(!rst_i) |-> card_specific_data_o[21] == 1'b0)
      else $error("partial write flag set");
   group_avail_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE_12]
      $past(!rst_i) |-> card_specific_data_o[31] == 1'b1)
      else $error("protect group flag clear");
   group_size_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE_13]
      $past(!rst_i) |-> card_specific_data_o[36:32] == 5'h0F)
      else $error("protect group size code wrong");
   erase_geometry_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE_14]
      $past(!rst_i) |-> card_specific_data_o[46:37] == 10'h3FF)
      else $error("erase group codes wrong");
   view_matches_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE_15]
      $past(!rst_i) |-> card_specific_data_o == $past(image))
      else $error("parallel view lags wrongly");

   // ************************************
   // checks of the programmable part
   // ************************************
   otp_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE_02]
      lock_cur[2] |=> otp_cur.permanent_protect_bit == $past(otp_cur.permanent_protect_bit))
      else $error("locked one-time field changed");
   format_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE_02]
      lock_cur[4] |=> otp_cur.format_group_bit == $past(otp_cur.format_group_bit))
      else $error("locked format group changed");
   copy_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE_02]
      lock_cur[3] |=> otp_cur.copy_bit == $past(otp_cur.copy_bit))
      else $error("locked copy flag changed");
   file_format_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE_02]
      lock_cur[1] |=> otp_cur.file_format == $past(otp_cur.file_format))
      else $error("locked file format changed");
   otp_lock_kept_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE_02]
      1'b1 |=> (lock_cur[4:1] & $past(lock_cur[4:1])) == $past(lock_cur[4:1]))
      else $error("one-time lock cleared");
   otp_first_write_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE_02]
      store_wr && !lock_cur[4] |=> lock_cur[4] && otp_cur.format_group_bit == $past(prog_data_i[15]))
      else $error("first one-time write lost");
   multi_write_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE_03]
      store_wr |=> multi_cur.crc_code == $past(prog_data_i[7:1]))
      else $error("rewritable field not stored");
   multi_fields_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE_03]
      store_wr |=> multi_cur.ecc_code == $past(prog_data_i[9:8])
      && multi_cur.temporary_protect_bit == $past(prog_data_i[12]))
      else $error("rewritable ecc or protect not stored");
   multi_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE_03]
      !store_wr |=> $stable(multi_cur))
      else $error("rewritable field changed without write");
   bad_prog_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE_01]
      prog_valid_i && fixed_mismatch |=> prog_reject_o && $stable(image))
      else $error("read-only change accepted");
   busy_prog_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE_01]
      prog_valid_i && read_busy_o |=> prog_reject_o && $stable(image))
      else $error("program accepted during readout");
   accept_prog_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE_01]
      prog_valid_i && !fixed_mismatch && !read_busy_o |=> !prog_reject_o)
      else $error("valid program refused");

   // ************************************
   // checks of the readout
   // ************************************
   first_bit_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE_15]
      !read_busy_o && read_req_i |=> ##1 read_bit_valid_o && read_bit_o == 1'b1)
      else $error("first bit not msb");
   read_len_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE_15]
      !read_busy_o && read_req_i |=> read_busy_o [*8] ##120 read_busy_o ##1 !read_busy_o && read_last_o)
      else $error("readout not 128 bits");
   busy_start_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE_15]
      !read_busy_o && read_req_i |=> read_busy_o)
      else $error("readout did not start");
   valid_busy_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE_15]
      read_bit_valid_o |-> $past(read_busy_o))
      else $error("serial bit outside readout");
   last_single_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE_15]
      read_last_o |=> !read_last_o)
      else $error("last marker longer than one cycle");
   last_bit_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE_15]
      read_last_o |-> read_bit_valid_o && read_bit_o == 1'b1)
      else $error("last bit not the fixed one");
endmodule : card_specific_data_register

// *** core/csd_cfg.svh ***
// constants of the card-specific data register: field positions and fixed values
// assumes inclusion by bare name from package and design files
`ifndef CSD_CFG_SVH
`define CSD_CFG_SVH
`define CSD_WIDTH 128
`define CSD_STRUCT_VAL 2'h3
`define CSD_SPEC_VAL 4'h4
`define CSD_ACCESS_TIME_VAL 8'h7F
`define CSD_ACCESS_CYCLE_VAL 8'h01
`define CSD_SPEED_VAL 8'h32
`define CSD_CLASSES_VAL 12'h8F5
`define CSD_RD_BLK_VAL 4'h9
`define CSD_DEV_SIZE_VAL 12'hFFF
`define CSD_SIZE_MULT_VAL 3'h7
`define CSD_ERASE_SIZE_VAL 5'h1F
`define CSD_ERASE_MULT_VAL 5'h1F
`define CSD_WP_SIZE_VAL 5'h0F
`define CSD_WP_AVAIL_VAL 1'h1
`define CSD_R2W_VAL 3'h1
`define CSD_WR_BLK_VAL 4'h9
`define CSD_RD_PARTIAL_VAL 1'h0
`define CSD_WR_PARTIAL_VAL 1'h0
`define CSD_BIT0_VAL 1'h1
`define CSD_LOCK_RESET 5'h00
`define CSD_STRUCT_RNG 127:126
`define CSD_SPEC_RNG 125:122
`define CSD_ACCESS_TIME_RNG 119:112
`define CSD_ACCESS_CYCLE_RNG 111:104
`define CSD_SPEED_RNG 103:96
`define CSD_CLASSES_RNG 95:84
`define CSD_RD_BLK_RNG 83:80
`define CSD_RD_PARTIAL_POS 79
`define CSD_DEV_SIZE_RNG 73:62
`define CSD_SIZE_MULT_RNG 49:47
`define CSD_ERASE_SIZE_RNG 46:42
`define CSD_ERASE_MULT_RNG 41:37
`define CSD_WP_SIZE_RNG 36:32
`define CSD_WP_AVAIL_POS 31
`define CSD_R2W_RNG 28:26
`define CSD_WR_BLK_RNG 25:22
`define CSD_WR_PARTIAL_POS 21
`define CSD_PROG_LSB 16
`define CSD_FMT_GRP_POS 15
`define CSD_COPY_POS 14
`define CSD_PERM_POS 13
`define CSD_TMP_POS 12
`define CSD_FILE_FMT_RNG 11:10
`define CSD_ECC_RNG 9:8
`define CSD_CRC_RNG 7:1
`define CSD_BIT0_POS 0
`define CSD_LOCK_FMT_GRP 4
`define CSD_LOCK_COPY 3
`define CSD_LOCK_PERM 2
`define CSD_LOCK_FILE_FMT 1
`define CSD_LOCK_SPARE 0
`define CSD_OTP_RESET 5'h00
`define CSD_MW_RESET 10'h000
`define CSD_BIT_CNT_W 7
`define CSD_LAST_BIT 7'h7F
`endif

// *** core/csd_pkg.sv ***
// types of the card-specific data register block
// assumes csd_cfg.svh on the include path
`include "csd_cfg.svh"
package csd_pkg;
   // one-time programmable fields
   typedef struct packed {
      logic format_group_bit;
      logic copy_bit;
      logic permanent_protect_bit;
      logic [1:0] file_format;
   } otp_type;
   // multiply-writable persistent fields
   typedef struct packed {
      logic temporary_protect_bit;
      logic [1:0] ecc_code;
      logic [6:0] crc_code;
   } multi_type;
   typedef enum logic [1:0] {
      idle_st,
      shift_st
   } mode_type;
endpackage : csd_pkg

// *** core/csd_store.sv ***
// persistent store of the programmable fields plus their once-written marks
// assumes no reset reaches it: contents survive power-on and command resets
`timescale 1ns/100ps
`include "csd_cfg.svh"
module csd_store (
   // clock
   input wire logic ref_clk_i,
   // write port
   input wire logic wr_en_i,
   input wire csd_pkg::otp_type otp_wr_i,
   input wire logic [4:0] otp_lock_wr_i,
   input wire csd_pkg::multi_type multi_wr_i,
   // read port
   output csd_pkg::otp_type otp_o,
   output logic [4:0] otp_lock_o,
   output csd_pkg::multi_type multi_o
);
   typedef struct packed {
      csd_pkg::otp_type otp;
      logic [4:0] lock;
      csd_pkg::multi_type multi;
   } store_type;
   store_type st = '{otp: `CSD_OTP_RESET, lock: `CSD_LOCK_RESET, multi: `CSD_MW_RESET};
   store_type next_st;
   always_comb begin
      next_st = st;
      if (wr_en_i) begin
         next_st.otp = otp_wr_i;
         next_st.lock = otp_lock_wr_i;
         next_st.multi = multi_wr_i;
      end
   end
   // no reset term: values stay across hardware and command resets
   always_ff @(posedge ref_clk_i) begin // [RULE_03]
      st <= next_st;
   end
   assign otp_o = st.otp;
   assign otp_lock_o = st.lock;
   assign multi_o = st.multi;
endmodule : csd_store

// *** dv/csd_host_model.sv ***
// host-side model: issues read and program requests and collects the serial answer
// assumes a 50 MHz clock from the bench; requests change at the falling edge
`timescale 1ns/100ps
module csd_host_model (
   // clock
   input wire logic ref_clk_i,
   // answer from the block
   input wire logic read_bit_i,
   input wire logic read_bit_valid_i,
   input wire logic read_last_i,
   input wire logic prog_reject_i,
   // requests to the block
   output logic read_req_o,
   output logic prog_valid_o,
   output logic [127:0] prog_data_o
);
   // ****************
   // request tasks
   // ****************
   initial begin
      read_req_o = 1'b0;
      prog_valid_o = 1'b0;
      prog_data_o = 128'h0;
   end
   // one-cycle program pulse; the reject flag is read in the cycle after
   task automatic send_image(input logic [127:0] data, output logic rej);
      @(negedge ref_clk_i);
      prog_valid_o = 1'b1;
      prog_data_o = data;
      @(negedge ref_clk_i);
      prog_valid_o = 1'b0;
      prog_data_o = ~data;
      rej = prog_reject_i;
      repeat (2) @(negedge ref_clk_i);
   endtask : send_image
   // bounded collection of the serial answer, msb first
   task automatic read_image(output logic [127:0] word, output logic ok);
      word = 128'h0;
      ok = 1'b0;
      @(negedge ref_clk_i);
      read_req_o = 1'b1;
      @(negedge ref_clk_i);
      read_req_o = 1'b0;
      for (int i = 0; i < 200 && ok == 1'b0; i++) begin
         @(negedge ref_clk_i);
         if (read_bit_valid_i === 1'b1) word = {word[126:0], read_bit_i};
         if (read_last_i === 1'b1) ok = 1'b1;
      end
   endtask : read_image
endmodule : csd_host_model

// *** dv/card_specific_data_register_bench.sv ***
// testbench of the card-specific data register: reads, programs, refusals, resets
// assumes csd_host_model as the host; inputs change at the falling edge
`timescale 1ns/100ps
module card_specific_data_register_bench;
   // ****************
   // signals
   // ****************
   localparam logic [111:0] fixed_hi = {2'h3, 4'h4, 2'h0, 8'h7F, 8'h01, 8'h32, 12'h8F5, 4'h9, 4'h0, 2'h0,
      12'hFFF, 12'h000, 3'h7, 5'h1F, 5'h1F, 5'h0F, 1'h1, 2'h0, 3'h1, 4'h9, 1'h0, 4'h0, 1'h0};
   localparam int bad_bits [5] = '{119, 121, 79, 31, 16};
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic prog_valid, read_req, busy, rd_bit, rd_valid, rd_last, reject, rej, ok;
   logic [127:0] prog_data, view, word, expect_img;
   int n_errors = 0;
   int compares = 0;
   always #10 ref_clk = ~ref_clk;
   card_specific_data_register DUT (.ref_clk_i(ref_clk), .rst_i(rst), .prog_valid_i(prog_valid),
      .prog_data_i(prog_data), .read_req_i(read_req), .read_busy_o(busy), .read_bit_o(rd_bit),
      .read_bit_valid_o(rd_valid), .read_last_o(rd_last), .card_specific_data_o(view),
      .prog_reject_o(reject));
   csd_host_model host (.ref_clk_i(ref_clk), .read_bit_i(rd_bit), .read_bit_valid_i(rd_valid),
      .read_last_i(rd_last), .prog_reject_i(reject), .read_req_o(read_req), .prog_valid_o(prog_valid),
      .prog_data_o(prog_data));
   // ****************
   // tasks
   // ****************
   task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic close_out();
      if (n_errors == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : close_out
   task automatic read_check(input logic [127:0] exp);
      host.read_image(word, ok);
      check("read done", 128'(ok), 128'h1);
      if (ok !== 1'b1) close_out();
      check("serial image", word, exp);
   endtask : read_check
   task automatic prog_check(input logic [127:0] data, input logic exp_rej, input logic [127:0] exp);
      host.send_image(data, rej);
      check("reject", 128'(rej), 128'(exp_rej));
      check("image", view, exp);
   endtask : prog_check
   // ****************
   // sequence
   // ****************
   initial begin
      expect_img = {fixed_hi, 16'h0001};
      repeat (3) @(negedge ref_clk);
      rst = 1'b0;
      repeat (2) @(negedge ref_clk);
      check("reset image", view, expect_img);
      check("fixed fields", view, expect_img);
      read_check(expect_img);
      for (int k = 0; k < 5; k++) begin
         prog_check(expect_img ^ (128'h1 << bad_bits[k]), 1'b1, expect_img);
      end
      expect_img = {fixed_hi, 16'hE955};
      prog_check(expect_img, 1'b0, expect_img);
      expect_img = {fixed_hi, 16'hFAAB};
      prog_check({fixed_hi, 16'h16AB}, 1'b0, expect_img);
      read_check(expect_img);
      fork
         read_check(expect_img);
         begin
            repeat (5) @(negedge ref_clk);
            check("busy during read", 128'(busy), 128'h1);
            prog_check({fixed_hi, 16'h0001}, 1'b1, expect_img);
         end
      join
      check("idle after read", 128'(busy), 128'h0);
      rst = 1'b1;
      repeat (3) @(negedge ref_clk);
      rst = 1'b0;
      repeat (2) @(negedge ref_clk);
      check("kept after reset", view, expect_img);
      read_check(expect_img);
      close_out();
   end
endmodule : card_specific_data_register_bench
